// ---- asq_consts.svh ----
// Register map, field positions and fixed figures of the scan sequencer
`ifndef ASQ_CONSTS_SVH
`define ASQ_CONSTS_SVH

// ============================================================
// Register byte offsets
`define ASQ_OFS_CTRL     8'h00
`define ASQ_OFS_CMD      8'h04
`define ASQ_OFS_STATUS   8'h08
`define ASQ_OFS_RESULT   8'h0c
`define ASQ_OFS_SCAN_INT 8'h10
`define ASQ_OFS_SMP_INT  8'h14
`define ASQ_OFS_POST     8'h18
`define ASQ_OFS_NSMP     8'h1c
`define ASQ_OFS_QUEUE    8'h20

// ============================================================
// Field positions
`define ASQ_CTRL_SCAN    0
`define ASQ_CTRL_EXT     1
`define ASQ_CTRL_HOLD    2
`define ASQ_CTRL_W       3
`define ASQ_CMD_START    0
`define ASQ_CMD_QCLR     1
`define ASQ_ST_READY     0
`define ASQ_ST_BUSY      1
`define ASQ_ST_ACTIVE    2
`define ASQ_ST_QLEN      25:16
`define ASQ_ENT_CH       6:0
`define ASQ_ENT_GAIN     9:8
`define ASQ_ENT_UNI      10
`define ASQ_ENT_CFG      13:12

// ============================================================
// Widths, depth and coding
`define ASQ_SI_W         24
`define ASQ_SI2_W        16
`define ASQ_PSC_W        24
`define ASQ_NSMP_W       9
`define ASQ_ENT_W        16
`define ASQ_Q_AW         9
`define ASQ_Q_DEPTH      10'd512
`define ASQ_SIGN_FLIP    16'h8000

`endif

// ---- asq_pkg.sv ----
// Types shared by the scan sequencer modules
package asq_pkg;
  typedef enum logic [1:0] {
    st_idle      = 2'b00,
    st_gap       = 2'b01,
    st_scan_wait = 2'b10
  } asq_state_t;
  typedef enum logic [1:0] {
    grounded_single_ended = 2'b00,
    floating_single_ended = 2'b01,
    differential_input    = 2'b10
  } asq_input_cfg_t;
endpackage

// ---- asq_result_fmt.sv ----
// Result formatter: straight-binary converter code to two's complement
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.svh"
module asq_result_fmt (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        capture,
  input  wire logic [15:0] raw,
  output logic      [15:0] result_r
);
  import asq_pkg::*;
  logic [15:0] result_nxt;

  // ============================================================
  // Midscale maps to zero in both polarities
  always_comb begin
    result_nxt = result_r;
    if (capture) begin
      result_nxt = raw ^ `ASQ_SIGN_FLIP;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      result_r <= '0;
    end else begin
      result_r <= result_nxt;
    end
  end

  chk_fmt_sign_flip: assert property (@(posedge hclk) disable iff (!hresetn)
    capture |=> result_r == ($past(raw) ^ `ASQ_SIGN_FLIP))
    else $error("result not in two's complement form");
endmodule
`default_nettype wire

// ---- asq_queue.sv ----
// Channel-gain queue: 512 entries, filled in order, read cyclically
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.svh"
module asq_queue (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  wr_en,
  input  wire logic [`ASQ_ENT_W-1:0] wr_data,
  input  wire logic                  clear,
  input  wire logic                  adv,
  output logic      [`ASQ_ENT_W-1:0] entry,
  output logic      [`ASQ_Q_AW:0]    length_r
);
  import asq_pkg::*;
  logic [`ASQ_ENT_W-1:0] mem [0:`ASQ_Q_DEPTH-1];
  logic [`ASQ_Q_AW-1:0]  rd_ptr_r;
  logic [`ASQ_Q_AW-1:0]  rd_ptr_nxt;
  logic [`ASQ_Q_AW:0]    length_nxt;
  logic                  last;

  assign entry = mem[rd_ptr_r];
  assign last  = ({1'b0, rd_ptr_r} + 10'h1) >= length_r;

  // ============================================================
  // Pointer and fill level
  always_comb begin
    length_nxt = length_r;
    rd_ptr_nxt = rd_ptr_r;
    if (clear) begin
      length_nxt = '0;
      rd_ptr_nxt = '0;
    end else begin
      if (wr_en && length_r < `ASQ_Q_DEPTH) begin
        length_nxt = length_r + 10'h1;
      end
      if (adv && length_r != '0) begin
        rd_ptr_nxt = last ? '0 : rd_ptr_r + 9'h1;
      end
    end
  end

  always_ff @(posedge hclk) begin
    if (wr_en && !clear && length_r < `ASQ_Q_DEPTH) begin
      mem[length_r[`ASQ_Q_AW-1:0]] <= wr_data;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      length_r <= '0;
      rd_ptr_r <= '0;
    end else begin
      length_r <= length_nxt;
      rd_ptr_r <= rd_ptr_nxt;
    end
  end

  chk_queue_wrap: assert property (@(posedge hclk) disable iff (!hresetn)
    adv && !clear && length_r != '0 && last |=> rd_ptr_r == '0)
    else $error("queue did not restart at first entry");
  chk_queue_order: assert property (@(posedge hclk) disable iff (!hresetn)
    adv && !clear && !last |=> rd_ptr_r == $past(rd_ptr_r) + 9'h1)
    else $error("queue skipped an entry");
  chk_queue_cap: assert property (@(posedge hclk) disable iff (!hresetn)
    length_r <= `ASQ_Q_DEPTH)
    else $error("queue length beyond capacity");
endmodule
`default_nettype wire

// ---- asq_top.sv ----
// Scan sequencer top: AHB-Lite registers, timebase, scan control
// Notes on behaviour
// - Each result is presented as a 16-bit two's complement word.
// - Bipolar: +full scale 7FFF, zero 0000, -1 LSB FFFF, -full scale 8000.
// - Unipolar: half range 0000, +1 LSB 0001, -1 LSB FFFF, top 7FFF.
// - Each software start command in idle, with scan off and a non-empty queue, performs exactly one conversion.
// - Queue entry holds channel, gain, polarity and input configuration.
// - Samples follow queue write order; channels may repeat in any order.
// - After the last entry the queue restarts from the first, unchanged.
// - The queue holds up to 512 entries.
// - 24-bit scan interval counts sample clock periods.
// - 16-bit sample interval spaces conversions within a scan.
// - 24-bit post-scan count sets scans acquired after start.
// - 9-bit count sets samples taken per scan.
// - In scan mode the first conversion starts on enable, every later one from the interval counters.
// - Software selects internal timebase or external clock for counters.
// - Hold strobe marks each scan start for external hold circuits.
//
// The placing of the registers and the AHB-Lite register port were decided locally.
`timescale 1ns/100ps
`default_nettype none
`include "asq_consts.svh"
module asq_top (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic      [31:0]           hrdata,
  input  wire logic                  external_sample_clock_in,
  input  wire logic                  adc_done_in,
  input  wire logic [15:0]           adc_data_in,
  output logic                       conv_start_out,
  output logic      [6:0]            chan_out,
  output logic      [1:0]            gain_out,
  output logic                       unipolar_out,
  output asq_pkg::asq_input_cfg_t    input_cfg_out,
  output logic                       scan_hold_strobe_out
);
  import asq_pkg::*;

  // ============================================================
  // Declarations
  logic [2:0]              ext_sync_r;
  logic [1:0]              done_sync_r;
  logic                    done_d_r;
  logic [15:0]             data_s1_r;
  logic [15:0]             data_s2_r;
  logic                    done_edge;
  logic                    tb_tick;
  logic                    addr_phase;
  logic                    rd_result;
  logic                    wr_pend_r;
  logic [7:0]              addr_r;
  logic [31:0]             hrdata_r;
  logic [31:0]             hrdata_nxt;
  logic [`ASQ_CTRL_W-1:0]  ctrl_r;
  logic [`ASQ_CTRL_W-1:0]  ctrl_nxt;
  logic [`ASQ_SI_W-1:0]    scan_int_r;
  logic [`ASQ_SI_W-1:0]    scan_int_nxt;
  logic [`ASQ_SI2_W-1:0]   smp_int_r;
  logic [`ASQ_SI2_W-1:0]   smp_int_nxt;
  logic [`ASQ_PSC_W-1:0]   post_r;
  logic [`ASQ_PSC_W-1:0]   post_nxt;
  logic [`ASQ_NSMP_W-1:0]  nsmp_r;
  logic [`ASQ_NSMP_W-1:0]  nsmp_nxt;
  logic                    ready_r;
  logic                    ready_nxt;
  logic                    busy_r;
  logic                    busy_nxt;
  logic                    sw_start;
  logic                    q_wr;
  logic                    q_clr;
  logic [`ASQ_ENT_W-1:0]   q_entry;
  logic [`ASQ_Q_AW:0]      q_len;
  logic [15:0]             result;
  asq_state_t              state_r;
  asq_state_t              state_nxt;
  logic [`ASQ_SI_W-1:0]    si_left_r;
  logic [`ASQ_SI_W-1:0]    si_left_nxt;
  logic [`ASQ_SI2_W-1:0]   si2_left_r;
  logic [`ASQ_SI2_W-1:0]   si2_left_nxt;
  logic [`ASQ_NSMP_W-1:0]  smp_cnt_r;
  logic [`ASQ_NSMP_W-1:0]  smp_cnt_nxt;
  logic [`ASQ_PSC_W-1:0]   psc_cnt_r;
  logic [`ASQ_PSC_W-1:0]   psc_cnt_nxt;
  logic                    issue;
  logic                    hold;
  logic                    start_scan;
  logic                    scan_fin;
  logic                    conv_r;
  logic                    hold_r;
  logic [`ASQ_ENT_W-1:0]   ent_r;
  logic [`ASQ_ENT_W-1:0]   ent_nxt;

  // ============================================================
  // Pin synchronisers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ext_sync_r  <= '0;
      done_sync_r <= '0;
      done_d_r    <= 1'b0;
      data_s1_r   <= '0;
      data_s2_r   <= '0;
    end else begin
      ext_sync_r  <= {ext_sync_r[1:0], external_sample_clock_in};
      done_sync_r <= {done_sync_r[0], adc_done_in};
      done_d_r    <= done_sync_r[1];
      data_s1_r   <= adc_data_in;
      data_s2_r   <= data_s1_r;
    end
  end

  assign done_edge = done_sync_r[1] & ~done_d_r;
  // Internal timebase ticks every clock
  assign tb_tick = ctrl_r[`ASQ_CTRL_EXT] ? (ext_sync_r[1] & ~ext_sync_r[2]) : 1'b1;

  // ============================================================
  // Submodules
  asq_queue u_queue (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .wr_en    (q_wr),
    .wr_data  (hwdata[`ASQ_ENT_W-1:0]),
    .clear    (q_clr),
    .adv      (issue),
    .entry    (q_entry),
    .length_r (q_len)
  );

  asq_result_fmt u_fmt (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .capture  (done_edge),
    .raw      (data_s2_r),
    .result_r (result)
  );

  // ============================================================
  // Bus slave and registers
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_result  = addr_phase & ~hwrite & (haddr[7:0] == `ASQ_OFS_RESULT);
  assign hreadyout  = 1'b1;
  assign hresp      = 1'b0;
  assign hrdata     = hrdata_r;

  always_comb begin
    ctrl_nxt     = ctrl_r;
    scan_int_nxt = scan_int_r;
    smp_int_nxt  = smp_int_r;
    post_nxt     = post_r;
    nsmp_nxt     = nsmp_r;
    sw_start     = 1'b0;
    q_wr         = 1'b0;
    q_clr        = 1'b0;
    hrdata_nxt   = hrdata_r;
    if (wr_pend_r) begin
      case (addr_r)
        `ASQ_OFS_CTRL:     ctrl_nxt = hwdata[`ASQ_CTRL_W-1:0];
        `ASQ_OFS_CMD: begin
          sw_start = hwdata[`ASQ_CMD_START];
          q_clr    = hwdata[`ASQ_CMD_QCLR];
        end
        `ASQ_OFS_SCAN_INT: scan_int_nxt = hwdata[`ASQ_SI_W-1:0];
        `ASQ_OFS_SMP_INT:  smp_int_nxt = hwdata[`ASQ_SI2_W-1:0];
        `ASQ_OFS_POST:     post_nxt = hwdata[`ASQ_PSC_W-1:0];
        `ASQ_OFS_NSMP:     nsmp_nxt = hwdata[`ASQ_NSMP_W-1:0];
        `ASQ_OFS_QUEUE:    q_wr = 1'b1;
        default: ;
      endcase
    end
    if (scan_fin) ctrl_nxt[`ASQ_CTRL_SCAN] = 1'b0;
    ready_nxt = ready_r;
    if (rd_result) ready_nxt = 1'b0;
    if (done_edge) ready_nxt = 1'b1;
    busy_nxt = busy_r;
    if (done_edge) busy_nxt = 1'b0;
    if (issue) busy_nxt = 1'b1;
    if (addr_phase && !hwrite) begin
      hrdata_nxt = '0;
      case (haddr[7:0])
        `ASQ_OFS_CTRL:     hrdata_nxt[`ASQ_CTRL_W-1:0] = ctrl_r;
        `ASQ_OFS_STATUS: begin
          hrdata_nxt[`ASQ_ST_READY]  = ready_r;
          hrdata_nxt[`ASQ_ST_BUSY]   = busy_r;
          hrdata_nxt[`ASQ_ST_ACTIVE] = state_r != st_idle;
          hrdata_nxt[`ASQ_ST_QLEN]   = q_len;
        end
        `ASQ_OFS_RESULT:   hrdata_nxt[15:0] = result;
        `ASQ_OFS_SCAN_INT: hrdata_nxt[`ASQ_SI_W-1:0] = scan_int_r;
        `ASQ_OFS_SMP_INT:  hrdata_nxt[`ASQ_SI2_W-1:0] = smp_int_r;
        `ASQ_OFS_POST:     hrdata_nxt[`ASQ_PSC_W-1:0] = post_r;
        `ASQ_OFS_NSMP:     hrdata_nxt[`ASQ_NSMP_W-1:0] = nsmp_r;
        `ASQ_OFS_QUEUE:    hrdata_nxt[`ASQ_Q_AW:0] = q_len;
        default:           hrdata_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r  <= 1'b0;
      addr_r     <= '0;
      hrdata_r   <= '0;
      ctrl_r     <= '0;
      scan_int_r <= '0;
      smp_int_r  <= '0;
      post_r     <= '0;
      nsmp_r     <= '0;
      ready_r    <= 1'b0;
      busy_r     <= 1'b0;
    end else begin
      wr_pend_r  <= addr_phase & hwrite;
      addr_r     <= addr_phase ? haddr[7:0] : addr_r;
      hrdata_r   <= hrdata_nxt;
      ctrl_r     <= ctrl_nxt;
      scan_int_r <= scan_int_nxt;
      smp_int_r  <= smp_int_nxt;
      post_r     <= post_nxt;
      nsmp_r     <= nsmp_nxt;
      ready_r    <= ready_nxt;
      busy_r     <= busy_nxt;
    end
  end

  // ============================================================
  // Scan state machine
  always_comb begin
    state_nxt    = state_r;
    si_left_nxt  = si_left_r;
    si2_left_nxt = si2_left_r;
    smp_cnt_nxt  = smp_cnt_r;
    psc_cnt_nxt  = psc_cnt_r;
    issue        = 1'b0;
    hold         = 1'b0;
    start_scan   = 1'b0;
    scan_fin     = 1'b0;
    case (state_r)
      st_idle: begin
        if (ctrl_r[`ASQ_CTRL_SCAN] && q_len != '0) begin
          start_scan  = 1'b1;
          psc_cnt_nxt = '0;
        end else if (sw_start && q_len != '0) begin
          issue = 1'b1;
        end
      end
      st_gap: begin
        if (tb_tick) begin
          si_left_nxt  = si_left_r - 24'h1;
          si2_left_nxt = si2_left_r - 16'h1;
          if (si2_left_r <= 16'h1) begin
            issue        = 1'b1;
            si2_left_nxt = smp_int_r;
            smp_cnt_nxt  = smp_cnt_r + 9'h1;
            if (smp_cnt_r + 9'h1 >= nsmp_r) begin
              state_nxt = st_scan_wait;
            end
          end
        end
      end
      st_scan_wait: begin
        if (tb_tick) begin
          si_left_nxt = si_left_r - 24'h1;
          if (si_left_r <= 24'h1) begin
            if (post_r != '0 && psc_cnt_r + 24'h1 >= post_r) begin
              scan_fin  = 1'b1;
              state_nxt = st_idle;
            end else begin
              psc_cnt_nxt = psc_cnt_r + 24'h1;
              start_scan  = 1'b1;
            end
          end
        end
      end
      default: state_nxt = st_idle;
    endcase
    if (start_scan) begin
      issue        = 1'b1;
      hold         = ctrl_r[`ASQ_CTRL_HOLD];
      si_left_nxt  = scan_int_r;
      si2_left_nxt = smp_int_r;
      smp_cnt_nxt  = 9'h1;
      state_nxt    = (nsmp_r > 9'h1) ? st_gap : st_scan_wait;
    end
    if (!ctrl_r[`ASQ_CTRL_SCAN] && state_r != st_idle) begin
      issue     = 1'b0;
      hold      = 1'b0;
      state_nxt = st_idle;
    end
    ent_nxt = issue ? q_entry : ent_r;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r    <= st_idle;
      si_left_r  <= '0;
      si2_left_r <= '0;
      smp_cnt_r  <= '0;
      psc_cnt_r  <= '0;
      conv_r     <= 1'b0;
      hold_r     <= 1'b0;
      ent_r      <= '0;
    end else begin
      state_r    <= state_nxt;
      si_left_r  <= si_left_nxt;
      si2_left_r <= si2_left_nxt;
      smp_cnt_r  <= smp_cnt_nxt;
      psc_cnt_r  <= psc_cnt_nxt;
      conv_r     <= issue;
      hold_r     <= hold;
      ent_r      <= ent_nxt;
    end
  end

  assign conv_start_out       = conv_r;
  assign scan_hold_strobe_out = hold_r;
  assign chan_out             = ent_r[`ASQ_ENT_CH];
  assign gain_out             = ent_r[`ASQ_ENT_GAIN];
  assign unipolar_out         = ent_r[`ASQ_ENT_UNI];
  assign input_cfg_out        = asq_input_cfg_t'(ent_r[`ASQ_ENT_CFG]);

  // ============================================================
  // Checks
  sequence seq_one_pulse;
    conv_start_out ##1 !conv_start_out;
  endsequence
  sequence seq_scan_open;
    conv_start_out && scan_hold_strobe_out == $past(ctrl_r[`ASQ_CTRL_HOLD]);
  endsequence
  chk_sw_one_conv: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == st_idle && !ctrl_r[`ASQ_CTRL_SCAN] && sw_start && q_len != '0
    |=> seq_one_pulse)
    else $error("software start did not give one conversion");
  chk_result_ready: assert property (@(posedge hclk) disable iff (!hresetn)
    done_edge |=> ready_r && result == ($past(data_s2_r) ^ `ASQ_SIGN_FLIP))
    else $error("finished conversion not flagged ready");
  chk_scan_first: assert property (@(posedge hclk) disable iff (!hresetn)
    start_scan && ctrl_r[`ASQ_CTRL_SCAN] |=> seq_scan_open)
    else $error("scan start lacks conversion or hold strobe");
  chk_sample_gap: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == st_gap && ctrl_r[`ASQ_CTRL_SCAN] && tb_tick && si2_left_r <= 16'h1
    |=> conv_start_out && si2_left_r == $past(smp_int_r))
    else $error("sample interval expiry gave no conversion");
  chk_no_stray_conv: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == st_gap && !tb_tick |=> !conv_start_out)
    else $error("conversion without a timebase tick");
  chk_scan_period: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == st_scan_wait && ctrl_r[`ASQ_CTRL_SCAN] && tb_tick && si_left_r <= 24'h1
    && (post_r == '0 || psc_cnt_r + 24'h1 < post_r) |=> conv_start_out ##1 !conv_start_out)
    else $error("scan interval expiry did not open a scan");
  chk_post_done: assert property (@(posedge hclk) disable iff (!hresetn)
    scan_fin |=> state_r == st_idle && !ctrl_r[`ASQ_CTRL_SCAN] ##1 state_r == st_idle)
    else $error("post-scan count did not end the run");
  chk_smp_count: assert property (@(posedge hclk) disable iff (!hresetn)
    state_r == st_gap |-> smp_cnt_r < nsmp_r)
    else $error("more samples than programmed in a scan");
  chk_int_tick: assert property (@(posedge hclk) disable iff (!hresetn)
    !ctrl_r[`ASQ_CTRL_EXT] |-> tb_tick)
    else $error("internal timebase missed a tick");
endmodule
`default_nettype wire

// ---- asq_adc_model.sv ----
// Converter model: answers each start pulse with a done level and data
`timescale 1ns/100ps
`default_nettype none
module asq_adc_model (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        conv_start_out,
  input  wire logic [15:0] raw_code,
  output logic             adc_done_in,
  output logic      [15:0] adc_data_in
);
  logic [2:0] cnt_r;
  // ============================================================
  // Conversion timing
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r       <= 3'h0;
      adc_done_in <= 1'b0;
      adc_data_in <= 16'h0000;
    end else if (conv_start_out) begin
      cnt_r       <= 3'h1;
      adc_data_in <= raw_code;
    end else if (cnt_r != 3'h0) begin
      cnt_r <= cnt_r + 3'h1;
      if (cnt_r == 3'h4) adc_done_in <= 1'b1;
      if (cnt_r == 3'h6) begin
        // Released data no longer shows the last value
        adc_done_in <= 1'b0;
        adc_data_in <= ~adc_data_in;
        cnt_r       <= 3'h0;
      end
    end
  end
endmodule
`default_nettype wire

// ---- test_adc_scan_sequencer.sv ----
// Self-checking bench of the scan sequencer
`timescale 1ns/100ps
`default_nettype none
module test_adc_scan_sequencer;
  import asq_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans, gain_out;
  logic [2:0] hsize;
  logic ext_clk, ext_run, done, conv_start_out, unipolar_out, hold;
  logic [15:0] adc_data, raw;
  logic [6:0] chan_out;
  asq_input_cfg_t input_cfg_out;
  int n_mismatch, n_tests, n_st, cyc, ec;
  int st_cyc[16];
  logic [11:0] st_ent[16];
  logic st_hold[16];
  logic [15:0] pent[4] = '{16'h0003, 16'h2201, 16'h1502, 16'h2201};
  logic [15:0] sent[3] = '{16'h0001, 16'h1102, 16'h2400};
  logic [15:0] raws[6] = '{16'hffff, 16'h8000, 16'h7fff, 16'h0000, 16'h8001, 16'h7ffe};
  assign hready = hreadyout;
  asq_top i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .external_sample_clock_in(ext_clk), .adc_done_in(done), .adc_data_in(adc_data),
    .conv_start_out(conv_start_out), .chan_out(chan_out), .gain_out(gain_out),
    .unipolar_out(unipolar_out), .input_cfg_out(input_cfg_out),
    .scan_hold_strobe_out(hold));
  asq_adc_model i_adc (.hclk(hclk), .hresetn(hresetn), .conv_start_out(conv_start_out),
    .raw_code(raw), .adc_done_in(done), .adc_data_in(adc_data));
  // ============================================================
  // Clock, external timebase and start monitor
  initial begin
    hclk = 1'b0;
    forever #20 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    ec = ec + 1;
    if (ext_run && ec % 4 == 0) ext_clk <= ~ext_clk;
    if (conv_start_out === 1'b1 && n_st < 16) begin
      st_cyc[n_st] = cyc;
      st_ent[n_st] = {input_cfg_out, unipolar_out, gain_out, chan_out};
      st_hold[n_st] = hold;
      n_st = n_st + 1;
    end
  end
  // ============================================================
  // Shared tasks
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hwait;
    int n;
    n = 0;
    while (hready !== 1'b1) begin
      if (++n > 50) begin
        n_mismatch++;
        summarize();
      end
      @(posedge hclk);
    end
  endtask
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    @(posedge hclk);
    hwait();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    @(posedge hclk);
    hwait();
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask
  task automatic rdr(input logic [31:0] a);
    xfer(1'b0, a, 32'h0);
  endtask
  task automatic wait_bit(input logic [31:0] a, input int b, input logic v);
    int n;
    n = 0;
    rdr(a);
    while (rd[b] !== v) begin
      if (++n > 200) begin
        n_mismatch++;
        summarize();
      end
      rdr(a);
    end
  endtask
  function automatic logic [11:0] pk(input logic [15:0] e);
    return {e[13:12], e[10], e[9:8], e[6:0]};
  endfunction
  // ============================================================
  // Scenarios
  task automatic t_reset;
    rdr(32'h00);
    chk("ctrl", 32'h0, rd);
    rdr(32'h08);
    chk("status", 32'h0, rd);
    wr(32'h40, 32'hffffffff);
    rdr(32'h40);
    chk("unmapped", 32'h0, rd);
    chk("hresp", 32'h0, {31'h0, hresp});
  endtask
  task automatic t_poll;
    for (int i = 0; i < 4; i++) wr(32'h20, {16'h0, pent[i]});
    for (int i = 0; i < 6; i++) begin
      raw = raws[i];
      n_st = 0;
      wr(32'h04, 32'h1);
      wait_bit(32'h08, 0, 1'b1);
      chk("starts", 32'd1, n_st);
      chk("entry", {20'h0, pk(pent[i % 4])}, {20'h0, st_ent[0]});
      rdr(32'h0c);
      chk("result", {16'h0, raws[i] ^ 16'h8000}, rd);
      rdr(32'h08);
      chk("ready", 32'h0, {31'h0, rd[0]});
    end
  endtask
  task automatic t_scan;
    wr(32'h04, 32'h2);
    n_st = 0;
    wr(32'h04, 32'h1);
    repeat (12) @(posedge hclk);
    chk("empty start", 32'd0, n_st);
    for (int i = 0; i < 513; i++) wr(32'h20, {16'h0, sent[i % 3]});
    rdr(32'h08);
    chk("qlen", 32'd512, {22'h0, rd[25:16]});
    wr(32'h10, 32'd48);
    wr(32'h14, 32'd14);
    wr(32'h18, 32'd2);
    wr(32'h1c, 32'd3);
    n_st = 0;
    wr(32'h00, 32'h5);
    wait_bit(32'h08, 2, 1'b1);
    wait_bit(32'h08, 2, 1'b0);
    chk("scan starts", 32'd6, n_st);
    for (int k = 0; k < 6; k++) begin
      chk("scan entry", {20'h0, pk(sent[k % 3])}, {20'h0, st_ent[k]});
      chk("hold", {31'h0, k % 3 == 0}, {31'h0, st_hold[k]});
      if (k % 3 != 0) chk("smp gap", 32'd14, st_cyc[k] - st_cyc[k - 1]);
    end
    chk("scan gap", 32'd48, st_cyc[3] - st_cyc[0]);
    rdr(32'h00);
    chk("scan_en", 32'h0, {31'h0, rd[0]});
  endtask
  task automatic t_ext;
    ext_run <= 1'b1;
    wr(32'h10, 32'd8);
    wr(32'h14, 32'd2);
    wr(32'h18, 32'd1);
    wr(32'h1c, 32'd3);
    n_st = 0;
    wr(32'h00, 32'h3);
    wait_bit(32'h08, 2, 1'b1);
    wait_bit(32'h08, 2, 1'b0);
    chk("ext starts", 32'd3, n_st);
    chk("ext gap", 32'd16, st_cyc[2] - st_cyc[1]);
    chk("no hold", 32'h0, {31'h0, st_hold[0]});
  endtask
  task automatic t_mid_reset;
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rdr(32'h00);
    chk("ctrl after reset", 32'h0, rd);
    rdr(32'h08);
    chk("status after reset", 32'h0, rd);
  endtask
  // ============================================================
  // Main sequence
  initial begin
    {hsel, hwrite, ext_clk, ext_run} = 4'h0;
    {haddr, hwdata} = 64'h0;
    htrans = 2'b00;
    hsize = 3'b010;
    raw = 16'h0000;
    {n_mismatch, n_tests, n_st, cyc, ec} = 0;
    hresetn = 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset();
    t_poll();
    t_scan();
    t_ext();
    t_mid_reset();
    summarize();
  end
endmodule
`default_nettype wire
